// ---- src/data_space_pkg.sv ----
// constants, offsets, reset values and carrier types of the data-space decoder
package data_space_pkg;

   // ****************************************************
   // data-space offsets
   // ****************************************************
   localparam logic [7:0] WIN_FIRST = 8'h40;
   localparam logic [7:0] WIN_LAST = 8'h7F;
   localparam logic [7:0] INDEX_X_ADDR = 8'h80;
   localparam logic [7:0] INDEX_Y_ADDR = 8'h81;
   localparam logic [7:0] SHORT_V_ADDR = 8'h82;
   localparam logic [7:0] SHORT_W_ADDR = 8'h83;
   localparam logic [7:0] PORT_A_DATA_ADDR = 8'hC0;
   localparam logic [7:0] PORT_B_DATA_ADDR = 8'hC1;
   localparam logic [7:0] PORT_A_DIR_ADDR = 8'hC4;
   localparam logic [7:0] PORT_B_DIR_ADDR = 8'hC5;
   localparam logic [7:0] INTR_OPT_ADDR = 8'hC8;
   localparam logic [7:0] WIN_SELECT_ADDR = 8'hC9;
   localparam logic [7:0] PORT_A_OPT_ADDR = 8'hCC;
   localparam logic [7:0] PORT_B_OPT_ADDR = 8'hCD;
   localparam logic [7:0] CONV_RESULT_ADDR = 8'hD0;
   localparam logic [7:0] CONV_CTRL_ADDR = 8'hD1;
   localparam logic [7:0] TIM_PRE_ADDR = 8'hD2;
   localparam logic [7:0] TIM_CNT_ADDR = 8'hD3;
   localparam logic [7:0] TIM_CTL_ADDR = 8'hD4;
   localparam logic [7:0] WDOG_ADDR = 8'hD8;
   localparam logic [7:0] ACC_ADDR = 8'hFF;

   // ****************************************************
   // field positions and reset values
   // ****************************************************
   localparam int WIN_OFS_BITS = 6;
   localparam int WIN_SEL_BITS = 6;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [7:0] CONV_CTRL_RESET = 8'h40;
   localparam logic [7:0] TIM_PRE_RESET = 8'h7F;
   localparam logic [7:0] TIM_CNT_RESET = 8'hFF;
   localparam logic [7:0] TIM_CTL_RESET = 8'h00;
   localparam logic [7:0] WDOG_RESET = 8'hFE;
   localparam logic [7:0] READ_FILL = 8'h00;

   // ****************************************************
   // carrier types
   // ****************************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } data_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] option;
   } port_pins_t;

   typedef struct packed {
      logic [7:0] intr_opt;
      logic [7:0] conv_ctrl;
      logic [7:0] tim_pre;
      logic [7:0] tim_cnt;
      logic [7:0] tim_ctl;
      logic [7:0] wdog;
   } periph_cfg_t;

   typedef enum logic {
      WIN_IDLE = 1'b0,
      WIN_FETCH = 1'b1
   } win_state_t;

endpackage : data_space_pkg

// ---- src/return_stack.sv ----
// hardware return-address stack, shift organised
module return_stack
   import data_space_pkg::*;
#(
   parameter int DEPTH = 6,
   parameter int WIDTH = 12
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [WIDTH-1:0] i_push_addr,
   output logic [WIDTH-1:0] o_top
);

   if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
      $error("return_stack: depth and width must be at least one");
   end

   logic [WIDTH-1:0] level [DEPTH];

   // push shifts down, pop shifts up; push wins when both
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            level[i] <= '0;
         end
      end else if (i_push) begin
         level[0] <= i_push_addr;
         for (int i = 1; i < DEPTH; i++) begin
            level[i] <= level[i-1];
         end
      end else if (i_pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            level[i] <= level[i+1];
         end
         level[DEPTH-1] <= '0;
      end
   end

   assign o_top = level[0];

endmodule : return_stack

// ---- src/port_regs.sv ----
// data, direction and option registers of one i/o port
module port_regs
   import data_space_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_wr_data,
   input wire logic i_wr_dir,
   input wire logic i_wr_opt,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_pins,
   output port_pins_t o_pins,
   output logic [7:0] o_data_read
);

   logic [7:0] data;
   logic [7:0] dir;
   logic [7:0] option;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         data <= PORT_RESET;
         dir <= PORT_RESET;
         option <= PORT_RESET;
      end else begin
         if (i_wr_data) begin
            data <= i_wdata;
         end
         if (i_wr_dir) begin
            dir <= i_wdata;
         end
         if (i_wr_opt) begin
            option <= i_wdata;
         end
      end
   end

   assign o_data_read = (dir & data) | (~dir & i_pins);
   assign o_pins = '{out: data, oe: dir, option: option};

endmodule : port_regs

// ---- src/data_space_map.sv ----
// data-space decoder with register map, rom window and return stack
// Notes on behaviour
// - six twelve-bit stack levels hold pushed return addresses, top at level 0.
// - reads of 40h..7Fh return program bytes from any block of 0000h..0FFFh.
// - program memory is 64 blocks of 64 bytes, block n at n*64.
// - fetch address: select bits 5:0 on top, window offset below.
// - window select keeps no reset value; software writes it before use.
// - window select at C9h, write-only, top two bits reserved as zero.
// - port data read gives latch for outputs, pin level for inputs.
// - port data registers at C0h, C1h, read-write, reset 00h.
// - port direction registers at C4h, C5h, read-write, reset 00h.
// - port option registers at CCh, CDh, read-write, reset 00h.
// - index, short direct at 80h..83h, accumulator FFh, read-write, no reset.
// - converter result D0h read-only; control D1h resets 40h, mixed bits.
// - timer registers D2h, D3h, D4h reset 7Fh, FFh, 00h, read-write.
// - first index register at 80h, second at 81h.
module data_space_map
   import data_space_pkg::*;
#(
   parameter int STACK_DEPTH = 6,
   parameter int PC_WIDTH = 12,
   parameter logic [7:0] CONV_RO_MASK = 8'h00,
   parameter logic [7:0] CONV_WO_MASK = 8'h00
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input data_req_t i_req,
   output logic o_req_ready,
   output logic o_rvalid,
   output logic [7:0] o_rdata,
   output logic o_pmem_rd,
   output logic [PC_WIDTH-1:0] o_pmem_addr,
   input wire logic [7:0] i_pmem_data,
   input wire logic i_push,
   input wire logic i_pop,
   input wire logic [PC_WIDTH-1:0] i_push_addr,
   output logic [PC_WIDTH-1:0] o_stack_top,
   input wire logic [7:0] i_port_a_pins,
   input wire logic [7:0] i_port_b_pins,
   output port_pins_t o_port_a,
   output port_pins_t o_port_b,
   input wire logic [7:0] i_conv_result,
   input wire logic [7:0] i_conv_status,
   output periph_cfg_t o_periph
);

   if (PC_WIDTH != WIN_SEL_BITS + WIN_OFS_BITS) begin : g_bad_pc_width
      $error("data_space_map: program counter width must equal select plus offset bits");
   end
   if ((CONV_RO_MASK & CONV_WO_MASK) != 8'h00) begin : g_bad_conv_masks
      $error("data_space_map: a converter bit cannot be read-only and write-only");
   end

   // ****************************************************
   // request decode
   // ****************************************************
   logic take;
   logic rd_take;
   logic wr_take;
   logic win_hit;
   logic [7:0] wd;
   win_state_t state;

   assign take = o_req_ready && (i_req.rd || i_req.wr);
   assign rd_take = o_req_ready && i_req.rd && !i_req.wr;
   assign wr_take = o_req_ready && i_req.wr;
   assign wd = i_req.wdata;
   assign win_hit = (i_req.addr >= WIN_FIRST) && (i_req.addr <= WIN_LAST);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction : hit

   // ****************************************************
   // core registers
   // ****************************************************
   logic [7:0] index_x;
   logic [7:0] index_y;
   logic [7:0] short_v;
   logic [7:0] short_w;
   logic [7:0] acc;
   logic [WIN_SEL_BITS-1:0] win_select;

   always_ff @(posedge i_ref_clk) begin
      if (wr_take && hit(i_req.addr, INDEX_X_ADDR)) begin
         index_x <= wd;
      end
      if (wr_take && hit(i_req.addr, INDEX_Y_ADDR)) begin
         index_y <= wd;
      end
      if (wr_take && hit(i_req.addr, SHORT_V_ADDR)) begin
         short_v <= wd;
      end
      if (wr_take && hit(i_req.addr, SHORT_W_ADDR)) begin
         short_w <= wd;
      end
      if (wr_take && hit(i_req.addr, ACC_ADDR)) begin
         acc <= wd;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (wr_take && hit(i_req.addr, WIN_SELECT_ADDR)) begin
         win_select <= wd[WIN_SEL_BITS-1:0];
      end
   end

   // ****************************************************
   // peripheral configuration
   // ****************************************************
   // converter control reset and mixed bits
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_periph.intr_opt <= 8'h00;
         o_periph.conv_ctrl <= CONV_CTRL_RESET;
         o_periph.tim_pre <= TIM_PRE_RESET;
         o_periph.tim_cnt <= TIM_CNT_RESET;
         o_periph.tim_ctl <= TIM_CTL_RESET;
         o_periph.wdog <= WDOG_RESET;
      end else if (wr_take) begin
         unique case (i_req.addr)
            INTR_OPT_ADDR: o_periph.intr_opt <= wd;
            CONV_CTRL_ADDR: o_periph.conv_ctrl <= (o_periph.conv_ctrl & CONV_RO_MASK) | (wd & ~CONV_RO_MASK);
            TIM_PRE_ADDR: o_periph.tim_pre <= wd;
            TIM_CNT_ADDR: o_periph.tim_cnt <= wd;
            TIM_CTL_ADDR: o_periph.tim_ctl <= wd;
            WDOG_ADDR: o_periph.wdog <= wd;
            default: begin
            end
         endcase
      end
   end

   // ****************************************************
   // i/o ports
   // ****************************************************
   logic [7:0] port_a_read;
   logic [7:0] port_b_read;

   port_regs port_a (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_wr_data(wr_take && hit(i_req.addr, PORT_A_DATA_ADDR)),
      .i_wr_dir(wr_take && hit(i_req.addr, PORT_A_DIR_ADDR)),
      .i_wr_opt(wr_take && hit(i_req.addr, PORT_A_OPT_ADDR)),
      .i_wdata(wd),
      .i_pins(i_port_a_pins),
      .o_pins(o_port_a),
      .o_data_read(port_a_read)
   );

   port_regs port_b (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_wr_data(wr_take && hit(i_req.addr, PORT_B_DATA_ADDR)),
      .i_wr_dir(wr_take && hit(i_req.addr, PORT_B_DIR_ADDR)),
      .i_wr_opt(wr_take && hit(i_req.addr, PORT_B_OPT_ADDR)),
      .i_wdata(wd),
      .i_pins(i_port_b_pins),
      .o_pins(o_port_b),
      .o_data_read(port_b_read)
   );

   // ****************************************************
   // stack space
   // ****************************************************
   // six return levels
   return_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_WIDTH)
   ) stack (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_push(i_push),
      .i_pop(i_pop),
      .i_push_addr(i_push_addr),
      .o_top(o_stack_top)
   );

   // ****************************************************
   // read multiplexer
   // ****************************************************
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = READ_FILL;
      unique case (i_req.addr)
         INDEX_X_ADDR: next_rdata = index_x;
         INDEX_Y_ADDR: next_rdata = index_y;
         SHORT_V_ADDR: next_rdata = short_v;
         SHORT_W_ADDR: next_rdata = short_w;
         ACC_ADDR: next_rdata = acc;
         PORT_A_DATA_ADDR: next_rdata = port_a_read;
         PORT_B_DATA_ADDR: next_rdata = port_b_read;
         PORT_A_DIR_ADDR: next_rdata = o_port_a.oe;
         PORT_B_DIR_ADDR: next_rdata = o_port_b.oe;
         PORT_A_OPT_ADDR: next_rdata = o_port_a.option;
         PORT_B_OPT_ADDR: next_rdata = o_port_b.option;
         CONV_RESULT_ADDR: next_rdata = i_conv_result;
         CONV_CTRL_ADDR: begin
            next_rdata = (o_periph.conv_ctrl & ~(CONV_RO_MASK | CONV_WO_MASK)) | (i_conv_status & CONV_RO_MASK);
         end
         TIM_PRE_ADDR: next_rdata = o_periph.tim_pre;
         TIM_CNT_ADDR: next_rdata = o_periph.tim_cnt;
         TIM_CTL_ADDR: next_rdata = o_periph.tim_ctl;
         WDOG_ADDR: next_rdata = o_periph.wdog;
         // reserved and write-only read as fill
         default: next_rdata = READ_FILL;
      endcase
   end

   // ****************************************************
   // window fetch and read answer
   // ****************************************************
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= WIN_IDLE;
         o_req_ready <= 1'b1;
         o_pmem_rd <= 1'b0;
      end else begin
         unique case (state)
            WIN_IDLE: begin
               if (rd_take && win_hit) begin
                  state <= WIN_FETCH;
                  o_req_ready <= 1'b0;
                  o_pmem_rd <= 1'b1;
               end
            end
            WIN_FETCH: begin
               state <= WIN_IDLE;
               o_req_ready <= 1'b1;
               o_pmem_rd <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pmem_addr <= '0;
      end else if (rd_take && win_hit) begin
         o_pmem_addr <= {win_select, i_req.addr[WIN_OFS_BITS-1:0]};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rvalid <= 1'b0;
         o_rdata <= READ_FILL;
      end else if (state == WIN_FETCH) begin
         o_rvalid <= 1'b1;
         o_rdata <= i_pmem_data;
      end else if (rd_take && !win_hit) begin
         o_rvalid <= 1'b1;
         o_rdata <= next_rdata;
      end else begin
         o_rvalid <= 1'b0;
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   AST_STACK_PUSH: assert property (i_push |=> o_stack_top == $past(i_push_addr))
      else $error("stack top does not hold the pushed address");
   AST_WIN_DATA: assert property (rd_take && win_hit |=> o_pmem_rd ##1 (o_rvalid && o_rdata == $past(i_pmem_data)))
      else $error("window read did not return the program byte two cycles on");
   AST_WIN_ONLY: assert property ($rose(o_pmem_rd) |-> $past(rd_take && win_hit))
      else $error("program fetch without a window read");
   AST_WIN_ADDR: assert property (rd_take && win_hit |=> o_pmem_addr == {$past(win_select), $past(i_req.addr[5:0])})
      else $error("window fetch address not select over offset");
   AST_SEL_WRITE: assert property (wr_take && i_req.addr == WIN_SELECT_ADDR |=> win_select == $past(wd[5:0]))
      else $error("window select did not take the written block");
   AST_PORT_READ: assert property (rd_take && i_req.addr == PORT_A_DATA_ADDR |=>
         o_rvalid && o_rdata == $past((o_port_a.oe & o_port_a.out) | (~o_port_a.oe & i_port_a_pins)))
      else $error("port read mixes latch and pins wrongly");
   AST_PORT_DATA: assert property (wr_take && i_req.addr == PORT_B_DATA_ADDR |=> o_port_b.out == $past(wd))
      else $error("port data write lost");
   AST_PORT_DIR: assert property (wr_take && i_req.addr == PORT_A_DIR_ADDR |=> o_port_a.oe == $past(wd))
      else $error("port direction write lost");
   AST_PORT_OPT: assert property (wr_take && i_req.addr == PORT_B_OPT_ADDR |=> o_port_b.option == $past(wd))
      else $error("port option write lost");
   AST_ACC_READ: assert property (rd_take && i_req.addr == ACC_ADDR |=> o_rvalid && o_rdata == $past(acc))
      else $error("accumulator read mismatch");
   AST_TIMER_WR: assert property (wr_take && i_req.addr == TIM_CNT_ADDR |=> o_periph.tim_cnt == $past(wd))
      else $error("timer downcounter write lost");
   AST_RESERVED: assert property (wr_take && i_req.addr == 8'hC2 |=> $stable(o_periph) && $stable(o_port_a))
      else $error("reserved write changed a register");
   AST_WDOG_WR: assert property (wr_take && i_req.addr == WDOG_ADDR |=> o_periph.wdog == $past(wd))
      else $error("watchdog write lost");
   AST_BUSY: assert property (o_pmem_rd |-> !o_req_ready ##1 o_req_ready)
      else $error("ready not restored after the fetch");
   AST_IDX_Y: assert property (rd_take && i_req.addr == INDEX_Y_ADDR |=>
         o_rvalid && o_rdata == $past(index_y))
      else $error("second index register read mismatch");
   AST_SHORT_W: assert property (rd_take && i_req.addr == SHORT_W_ADDR |=>
         o_rvalid && o_rdata == $past(short_w))
      else $error("short direct register read mismatch");
   AST_RES_READ: assert property (rd_take && i_req.addr == 8'hC2 |=> o_rvalid && o_rdata == READ_FILL)
      else $error("reserved read did not return the fill value");
   AST_CONV_RO: assert property (wr_take && i_req.addr == CONV_CTRL_ADDR |=>
         ((o_periph.conv_ctrl ^ $past(o_periph.conv_ctrl)) & CONV_RO_MASK) == 8'h00)
      else $error("read-only converter control bit was written");
   AST_CONV_READ: assert property (rd_take && i_req.addr == CONV_RESULT_ADDR |=>
         o_rvalid && o_rdata == $past(i_conv_result))
      else $error("converter result read mismatch");
   AST_PORT_B_READ: assert property (rd_take && i_req.addr == PORT_B_DATA_ADDR |=>
         o_rvalid && o_rdata == $past((o_port_b.oe & o_port_b.out) | (~o_port_b.oe & i_port_b_pins)))
      else $error("port b read mixes latch and pins wrongly");
   AST_DIR_B: assert property (wr_take && i_req.addr == PORT_B_DIR_ADDR |=> o_port_b.oe == $past(wd))
      else $error("port b direction write lost");
   AST_WR_QUIET: assert property (wr_take |=> !o_rvalid)
      else $error("a write produced a read answer");
   AST_REFUSED: assert property (!o_req_ready |=> $stable(o_periph))
      else $error("a request was taken while not ready");

   COV_WIN_READ: cover property (rd_take && win_hit ##2 o_rvalid);
   COV_PORT_INPUT: cover property (rd_take && i_req.addr == PORT_A_DATA_ADDR && o_port_a.oe == 8'h00);
   COV_PUSH_POP: cover property (i_push ##1 i_pop);
   COV_SEL_THEN_READ: cover property (wr_take && i_req.addr == WIN_SELECT_ADDR ##1 rd_take && win_hit);
   COV_WRITE_PAIR: cover property (take && i_req.wr ##2 take);

endmodule : data_space_map

// ---- tb/core_port_model.sv ----
// processor core side: data-space request driver and program memory model
module core_port_model
   import data_space_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_req_ready,
   input wire logic i_rvalid,
   input wire logic [7:0] i_rdata,
   input wire logic i_pmem_rd,
   input wire logic [11:0] i_pmem_addr,
   output data_req_t o_req,
   output logic [7:0] o_pmem_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] pattern;

   // ****************************************************
   // program memory
   // ****************************************************
   // byte tied to block and offset; inverted outside the strobe
   assign pattern = i_pmem_addr[7:0] ^ {2'b00, i_pmem_addr[11:6]};
   assign o_pmem_data = i_pmem_rd ? pattern : ~pattern;

   // ****************************************************
   // request driver
   // ****************************************************
   initial o_req = '0;

   // held until an edge samples ready high, released there
   task automatic bus_req(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
      int n = 0;
      @(posedge i_ref_clk);
      o_req <= '{rd: rd, wr: ~rd, addr: addr, wdata: wdata};
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (i_req_ready !== 1'b1 && n < 8);
      o_req <= '0;
   endtask : bus_req

   task automatic bus_rd(input logic [7:0] addr, output logic [7:0] data);
      int n = 0;
      bus_req(1'b1, addr, 8'h00);
      // register answers stand in the cycle right after the taking edge
      #1;
      while (i_rvalid !== 1'b1 && n < 4) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      data = (i_rvalid === 1'b1) ? i_rdata : 'x;
   endtask : bus_rd
endmodule : core_port_model

// ---- tb/data_space_map_rom_window_tb.sv ----
// self-checking bench for the data-space decoder
module data_space_map_rom_window_tb import data_space_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   data_req_t req;
   logic req_ready, rvalid, pmem_rd;
   logic push = 1'b0, pop = 1'b0;
   logic [7:0] rdata, pmem_data, rd;
   logic [7:0] pins_a = 8'h00, pins_b = 8'h00, conv_res = 8'h00, conv_stat = 8'h43;
   localparam logic [7:0] RO_BITS = 8'h80;
   localparam logic [7:0] WO_BITS = 8'h01;
   logic [11:0] pmem_addr, top, push_addr = 12'h000;
   port_pins_t port_a, port_b;
   periph_cfg_t periph;
   int err_count = 0, checks_done = 0, cycles = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   data_space_map #(.CONV_RO_MASK(RO_BITS), .CONV_WO_MASK(WO_BITS)) uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_req(req), .o_req_ready(req_ready),
      .o_rvalid(rvalid), .o_rdata(rdata), .o_pmem_rd(pmem_rd), .o_pmem_addr(pmem_addr),
      .i_pmem_data(pmem_data), .i_push(push), .i_pop(pop), .i_push_addr(push_addr),
      .o_stack_top(top), .i_port_a_pins(pins_a), .i_port_b_pins(pins_b), .o_port_a(port_a),
      .o_port_b(port_b), .i_conv_result(conv_res), .i_conv_status(conv_stat), .o_periph(periph));

   core_port_model core (.i_ref_clk(i_ref_clk), .i_req_ready(req_ready), .i_rvalid(rvalid),
      .i_rdata(rdata), .i_pmem_rd(pmem_rd), .i_pmem_addr(pmem_addr), .o_req(req), .o_pmem_data(pmem_data));

   // ****************************************************
   // checking helpers
   // ****************************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_count++;
         stop_test();
      end
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
      core.bus_rd(addr, rd);
      chk({4'h0, rd}, {4'h0, exp});
   endtask : rchk

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic test_reset;
      logic [7:0] ad [11] = '{8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD8};
      logic [7:0] ex [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h7F, 8'hFF, 8'h00, 8'hFE};
      chk(top, 12'h000);
      foreach (ad[i]) rchk(ad[i], ex[i]);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_rw;
      logic [7:0] ad [14] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'hC0, 8'hC1, 8'hCC, 8'hCD, 8'hD1, 8'hD2,
         8'hD3, 8'hD4, 8'hD8};
      core.bus_req(1'b0, PORT_A_DIR_ADDR, 8'hFF);
      core.bus_req(1'b0, PORT_B_DIR_ADDR, 8'hFF);
      foreach (ad[i]) core.bus_req(1'b0, ad[i], ad[i] ^ 8'h5A);
      // converter control: bit 7 read-only (status 0), bit 0 write-only
      foreach (ad[i]) begin
         rchk(ad[i], (ad[i] == CONV_CTRL_ADDR) ? 8'h0A : ad[i] ^ 8'h5A);
      end
      chk({4'h0, port_a.oe}, 12'h0FF);
      chk({4'h0, periph.wdog}, 12'h082);
      chk({4'h0, periph.conv_ctrl}, 12'h00B);
      $display("test_rw done");
   endtask : test_rw

   task automatic test_port;
      @(posedge i_ref_clk);
      pins_a <= 8'h3C;
      pins_b <= 8'h3C;
      core.bus_req(1'b0, PORT_A_DIR_ADDR, 8'h0F);
      core.bus_req(1'b0, PORT_A_DATA_ADDR, 8'h05);
      core.bus_req(1'b0, PORT_B_DIR_ADDR, 8'hF0);
      core.bus_req(1'b0, PORT_B_DATA_ADDR, 8'hA5);
      rchk(PORT_A_DATA_ADDR, 8'h35);
      rchk(PORT_B_DATA_ADDR, 8'hAC);
      chk({4'h0, port_a.out}, 12'h005);
      chk({4'h0, port_b.oe}, 12'h0F0);
      $display("test_port done");
   endtask : test_port

   task automatic test_reserved;
      logic [7:0] ad [11] = '{8'hC2, 8'hC3, 8'hC6, 8'hC7, 8'hCA, 8'hCF, 8'hD5, 8'hD9, 8'hFE, 8'h84, 8'h10};
      periph_cfg_t snap;
      port_pins_t sa;
      snap = periph;
      sa = port_a;
      foreach (ad[i]) core.bus_req(1'b0, ad[i], 8'hFF);
      foreach (ad[i]) rchk(ad[i], READ_FILL);
      chk({11'h000, periph === snap}, 12'h001);
      chk({11'h000, port_a === sa}, 12'h001);
      @(posedge i_ref_clk);
      conv_res <= 8'h96;
      conv_stat <= 8'hC3;
      core.bus_req(1'b0, CONV_RESULT_ADDR, 8'h11);
      rchk(CONV_RESULT_ADDR, 8'h96);
      rchk(CONV_CTRL_ADDR, 8'h8A);
      core.bus_req(1'b0, INTR_OPT_ADDR, 8'h3C);
      rchk(INTR_OPT_ADDR, READ_FILL);
      chk({4'h0, periph.intr_opt}, 12'h03C);
      $display("test_reserved done");
   endtask : test_reserved

   task automatic test_window;
      logic [5:0] sel [6] = '{6'h00, 6'h00, 6'h01, 6'h3F, 6'h3F, 6'h2A};
      logic [5:0] ofs [6] = '{6'h00, 6'h3F, 6'h00, 6'h00, 6'h3F, 6'h15};
      logic [11:0] a;
      logic [7:0] sel_image;
      for (int i = 0; i < 6; i++) begin
         sel_image = {2'b00, sel[i]};
         core.bus_req(1'b0, WIN_SELECT_ADDR, sel_image);
         for (int k = 0; k < 2; k++) begin
            a = {sel[i], ofs[i] ^ {6{k[0]}}};
            core.bus_rd(WIN_FIRST | {2'b00, a[5:0]}, rd);
            chk(pmem_addr, a);
            chk({4'h0, rd}, {4'h0, a[7:0] ^ {2'b00, a[11:6]}});
         end
      end
      $display("test_window done");
   endtask : test_window

   task automatic test_stack;
      for (int i = 1; i <= 7; i++) begin
         @(posedge i_ref_clk);
         push <= 1'b1;
         push_addr <= 12'h100 + 12'(i);
         @(posedge i_ref_clk);
         push <= 1'b0;
         #1;
         chk(top, 12'h100 + 12'(i));
      end
      for (int i = 6; i >= 1; i--) begin
         @(posedge i_ref_clk);
         pop <= 1'b1;
         @(posedge i_ref_clk);
         pop <= 1'b0;
         #1;
         chk(top, (i > 1) ? 12'h100 + 12'(i) : 12'h000);
      end
      $display("test_stack done");
   endtask : test_stack

   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      test_reset();
      test_rw();
      test_port();
      test_reserved();
      test_window();
      test_stack();
      stop_test();
   end
endmodule : data_space_map_rom_window_tb
